/* File: common/crg_pkg.sv */
/*
  Shared constants, state type and decode functions for the clock, ready
  and reset generator. Assumes a single system clock domain; the
  importing modules reference every item as crg_pkg::name.
*/
package crg_pkg;

  // synchroniser lane indices and their reset levels
  localparam int       SYNC_WIDTH = 3;
  localparam int       SYNC_RES   = 0;
  localparam int       SYNC_ASYNC_READY_IN_N  = 1;
  localparam int       SYNC_AQUAL = 2;
  // request asserted, async ready and qualifier inactive
  localparam logic [2:0] SYNC_INIT = 3'h6;

  localparam logic PCLK_INIT   = 1'h0;
  localparam logic RESET_INIT  = 1'h1;
  localparam logic STRAP_INIT  = 1'h0;
  localparam logic READY_LEVEL = 1'h0;

  typedef enum logic [1:0] {
    CRG_RDY_OFF   = 2'b00,
    CRG_RDY_FIRST = 2'b01,
    CRG_RDY_ON    = 2'b10
  } crg_ready_state_type;

  // a status pin low marks a bus cycle start; pull-ups keep idle pins high
  function automatic logic status_active(input logic s0_n, input logic s1_n);
    return !s0_n || !s1_n;
  endfunction

  function automatic logic source_selected(input logic rdy_n, input logic qual_n);
    return !rdy_n && !qual_n;
  endfunction

endpackage

/* File: hw/crg_sync_3ff.sv */
/*
  Three flip-flop synchroniser for one asynchronous input.
  Assumes the input may change at any time relative to clock_i; the
  output moves only when the second and third stages agree.
*/
`timescale 1ns/100ps
module crg_sync_3ff #(
  parameter logic INIT = 1'h1
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic din_i,
  output logic      dout_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } crg_sync_state_type;

  crg_sync_state_type state;
  crg_sync_state_type next_state;

  always_comb begin
    next_state    = state;
    // first stage feeds only the second
    next_state.s1 = din_i;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    if (state.s2 == state.s3) begin
      next_state.val = state.s3;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '{s1: INIT, s2: INIT, s3: INIT, val: INIT};
    end else begin
      state <= next_state;
    end
  end

  assign dout_o = state.val;

  a_sync_agree: assert property (@(posedge clock_i) disable iff (rst_i)
      (state.s2 == state.s3) |=> (state.val == $past(state.s3)))
    else $error("synchroniser output missed an agreed level");

endmodule

/* File: hw/crg_pclk_gen.sv */
/*
  Peripheral clock generator: halves the system clock and realigns its
  phase from the processor status inputs. Assumes the status inputs are
  synchronous to clock_i and meet its setup and hold.
*/
`timescale 1ns/100ps
module crg_pclk_gen (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic bus_status_zero_n_i,
  input  wire logic bus_status_one_n_i,
  output logic      pclk_o
);

  typedef struct packed {
    logic pclk;
    logic stat_prev;
  } crg_pclk_state_type;

  crg_pclk_state_type state;
  crg_pclk_state_type next_state;
  logic               stat_now;

  assign stat_now = crg_pkg::status_active(bus_status_zero_n_i, bus_status_one_n_i);

  always_comb begin
    next_state           = state;
    next_state.stat_prev = stat_now;
    // forcing only ever holds the clock high, so a phase can grow, never shrink
    if (stat_now && state.stat_prev) begin
      next_state.pclk = 1'h1;
    end else begin
      next_state.pclk = !state.pclk;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '{pclk: crg_pkg::PCLK_INIT, stat_prev: 1'h0};
    end else begin
      state <= next_state;
    end
  end

  assign pclk_o = state.pclk;

  a_pclk_force: assert property (@(posedge clock_i) disable iff (rst_i)
      (stat_now && state.stat_prev) |=> pclk_o)
    else $error("peripheral clock not held high under status");

  a_pclk_toggle: assert property (@(posedge clock_i) disable iff (rst_i)
      !(stat_now && state.stat_prev) |=> (pclk_o != $past(pclk_o)))
    else $error("peripheral clock failed to toggle");

  a_pclk_low_short: assert property (@(posedge clock_i) disable iff (rst_i)
      (!pclk_o ##1 1'h1) |-> pclk_o)
    else $error("peripheral clock low phase stretched");

endmodule

/* File: hw/crg_clock_ready_reset.sv */
/*
  Clock, ready and reset generator top. Selects the system clock source,
  produces the peripheral clock, a synchronised active-high reset and an
  open-drain active-low ready. Assumes clock_i is the system clock, the
  status and synchronous ready inputs are synchronous to it, and the
  ready line has an external pull-up.
*/
`timescale 1ns/100ps
module crg_clock_ready_reset (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic clock_select_strap_i,
  input  wire logic crystal_pins_i,
  input  wire logic external_frequency_in_i,
  output logic      system_clock_o,
  output logic      pclk_o,
  input  wire logic bus_status_zero_n_i,
  input  wire logic bus_status_one_n_i,
  input  wire logic reset_request_in_n_i,
  output logic      reset_o,
  input  wire logic async_ready_in_n_i,
  input  wire logic async_ready_qualifier_n_i,
  input  wire logic sync_ready_in_n_i,
  input  wire logic sync_ready_qualifier_n_i,
  input  wire logic ready_line_i,
  output logic      ready_out_o,
  output logic      ready_oe_o
);

  typedef struct packed {
    logic                         strap_efi;
    logic                         reset_out;
    crg_pkg::crg_ready_state_type rdy;
  } crg_top_state_type;

  crg_top_state_type                 state;
  crg_top_state_type                 next_state;
  logic [crg_pkg::SYNC_WIDTH-1:0]    sync_in;
  logic [crg_pkg::SYNC_WIDTH-1:0]    sync_out;
  logic                              stat_now;
  logic                              async_sel;
  logic                              sync_sel;
  logic                              any_sel;
  logic                              pclk;
  logic                              ready_active;
  logic                              line_seen;

  // asynchronous pins pass through their own three-stage synchroniser
  assign sync_in[crg_pkg::SYNC_RES]   = reset_request_in_n_i;
  assign sync_in[crg_pkg::SYNC_ASYNC_READY_IN_N]  = async_ready_in_n_i;
  assign sync_in[crg_pkg::SYNC_AQUAL] = async_ready_qualifier_n_i;

  genvar g;
  generate
    for (g = 0; g < crg_pkg::SYNC_WIDTH; g++) begin : g_sync
      crg_sync_3ff #(
        .INIT (crg_pkg::SYNC_INIT[g])
      ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .din_i   (sync_in[g]),
        .dout_o  (sync_out[g])
      );
    end
  endgenerate

  crg_pclk_gen u_pclk (
    .clock_i             (clock_i),
    .rst_i               (rst_i),
    .bus_status_zero_n_i (bus_status_zero_n_i),
    .bus_status_one_n_i  (bus_status_one_n_i),
    .pclk_o              (pclk)
  );

  assign pclk_o = pclk;

  // the clock source is fixed by the strap caught during reset
  assign system_clock_o = state.strap_efi ? external_frequency_in_i
                                          : crystal_pins_i;

  assign stat_now  = crg_pkg::status_active(bus_status_zero_n_i,
                                            bus_status_one_n_i);
  assign async_sel = crg_pkg::source_selected(sync_out[crg_pkg::SYNC_ASYNC_READY_IN_N],
                                              sync_out[crg_pkg::SYNC_AQUAL]);
  // synchronous pair is used raw: the far side meets setup and hold
  assign sync_sel  = crg_pkg::source_selected(sync_ready_in_n_i,
                                              sync_ready_qualifier_n_i);
  assign any_sel   = async_sel || sync_sel;

  always_comb begin
    next_state           = state;
    next_state.reset_out = !sync_out[crg_pkg::SYNC_RES];
    if (state.reset_out) begin
      // ready is forced active one cycle after reset shows
      next_state.rdy = crg_pkg::CRG_RDY_ON;
    end else if (stat_now) begin
      // a new bus cycle always starts not ready
      next_state.rdy = crg_pkg::CRG_RDY_OFF;
    end else begin
      case (state.rdy)
        crg_pkg::CRG_RDY_OFF: begin
          // sources are looked at only in the high half of the peripheral clock
          if (pclk && any_sel) begin
            next_state.rdy = crg_pkg::CRG_RDY_FIRST;
          end
        end
        crg_pkg::CRG_RDY_FIRST: begin
          // minimum hold: a dropped source cannot release here
          next_state.rdy = crg_pkg::CRG_RDY_ON;
        end
        crg_pkg::CRG_RDY_ON: begin
          if (pclk && !any_sel) begin
            next_state.rdy = crg_pkg::CRG_RDY_OFF;
          end
        end
        default: begin
          next_state.rdy = crg_pkg::CRG_RDY_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // strap is a static level, caught while reset is held
      state.strap_efi <= clock_select_strap_i;
      state.reset_out <= crg_pkg::RESET_INIT;
      state.rdy       <= crg_pkg::CRG_RDY_ON;
    end else begin
      state <= next_state;
    end
  end

  assign reset_o      = state.reset_out;
  assign ready_active = (state.rdy != crg_pkg::CRG_RDY_OFF);

  // open drain: data is always the low level, only the enable moves
  assign ready_out_o  = crg_pkg::READY_LEVEL;
  assign ready_oe_o   = ready_active;

  // wired line read back is informational only; other sources may hold it
  assign line_seen    = ready_line_i;

  a_reset_follow: assert property (@(posedge clock_i) disable iff (rst_i)
      !sync_out[crg_pkg::SYNC_RES] |=> reset_o)
    else $error("reset output did not follow request");

  a_reset_synced: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(reset_o) |-> !$past(sync_out[crg_pkg::SYNC_RES]))
    else $error("reset output rose without synchronised request");

  a_ready_reset: assert property (@(posedge clock_i) disable iff (rst_i)
      reset_o |=> ready_oe_o)
    else $error("ready not active one cycle after reset");

  a_ready_status: assert property (@(posedge clock_i) disable iff (rst_i)
      (!reset_o && stat_now) |=> !ready_oe_o)
    else $error("ready not released at bus cycle start");

  a_ready_take: assert property (@(posedge clock_i) disable iff (rst_i)
      (!reset_o && !stat_now && pclk && any_sel) |=> ready_oe_o)
    else $error("qualified ready source not honoured");

  a_ready_min_two: assert property (@(posedge clock_i) disable iff (rst_i)
      ($rose(ready_oe_o) && !reset_o && !stat_now) |=> ready_oe_o)
    else $error("ready held for less than two cycles");

  a_ready_pclk_gate: assert property (@(posedge clock_i) disable iff (rst_i)
      (!reset_o && !stat_now && !pclk) |=> (ready_oe_o || !$past(ready_oe_o)) &&
                                           (!ready_oe_o || $past(ready_oe_o)))
    else $error("ready moved while peripheral clock low");

  a_ready_drop: assert property (@(posedge clock_i) disable iff (rst_i)
      (!reset_o && !stat_now && pclk && !any_sel && state.rdy == crg_pkg::CRG_RDY_ON)
      |=> !ready_oe_o)
    else $error("ready kept after sources went inactive");

  a_async_qual: assert property (@(posedge clock_i) disable iff (rst_i)
      (!reset_o && !stat_now && pclk && !sync_sel && sync_out[crg_pkg::SYNC_AQUAL] &&
       state.rdy == crg_pkg::CRG_RDY_OFF) |=> !ready_oe_o)
    else $error("unqualified async ready ended a cycle");

endmodule

/* File: testbench/crg_far_model.sv */
/*
  Far side model: processor status pins with pull-ups, wait-state ready
  decode and the pulled-up ready line. Assumes the bench system clock.
*/
`timescale 1ns/100ps
module crg_far_model (
  input  wire logic       clock_i,
  input  wire logic [1:0] pull_i,
  input  wire logic       async_i,
  input  wire logic       qoff_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       oe_i,
  output logic            s0_n_o,
  output logic            s1_n_o,
  output logic            async_ready_in_n_n_o,
  output logic            aq_n_o,
  output logic            sync_ready_in_n_n_o,
  output logic            sq_n_o,
  output logic            line_o
);
  logic [3:0] cnt = 4'h0;
  logic       go  = 1'h0;
  logic       act = 1'h0;
  assign s0_n_o = !pull_i[0];
  assign s1_n_o = !pull_i[1];
  assign line_o = !oe_i;
  // async lines move off the clock edge on purpose
  assign #13 async_ready_in_n_n_o = !(act && async_i);
  assign #13 aq_n_o = !(act && async_i && !qoff_i);
  // launched just after the edge, so setup and hold are met
  assign sync_ready_in_n_n_o = !(act && !async_i);
  assign sq_n_o = !(act && !async_i && !qoff_i);
  // ready stays offered until the next bus cycle starts
  always @(posedge clock_i) begin
    if (pull_i != 2'h0) begin
      go <= 1'h1;
      cnt <= wait_i;
      act <= 1'h0;
    end else if (go && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (go) begin
      act <= 1'h1;
    end
  end
endmodule

/* File: testbench/crg_clock_ready_reset_bench.sv */
/*
  Self-checking bench for the clock, ready and reset generator.
  Assumes the far side model is compiled first.
*/
`timescale 1ns/100ps
module crg_clock_ready_reset_bench;
  logic       clock_i = 1'h0;
  logic       rst_i   = 1'h1;
  logic       strap   = 1'h1;
  logic       xtal    = 1'h0;
  logic       external_frequency_in     = 1'h0;
  logic       req_n   = 1'h1;
  logic [1:0] pull    = 2'h0;
  logic       use_a   = 1'h0;
  logic       qoff    = 1'h0;
  logic [3:0] wt      = 4'h0;
  logic       sclk, pclk, rst_o, r_out, oe, line;
  logic       s0, s1, ar, aq, sr, sq;
  int         bad_count = 0;
  int         checked   = 0;
  int         n;
  initial forever #20 clock_i = ~clock_i;
  crg_clock_ready_reset uut (
    .clock_i(clock_i), .rst_i(rst_i), .clock_select_strap_i(strap),
    .crystal_pins_i(xtal), .external_frequency_in_i(external_frequency_in),
    .system_clock_o(sclk), .pclk_o(pclk),
    .bus_status_zero_n_i(s0), .bus_status_one_n_i(s1),
    .reset_request_in_n_i(req_n), .reset_o(rst_o),
    .async_ready_in_n_i(ar), .async_ready_qualifier_n_i(aq),
    .sync_ready_in_n_i(sr), .sync_ready_qualifier_n_i(sq),
    .ready_line_i(line), .ready_out_o(r_out), .ready_oe_o(oe));
  crg_far_model far (
    .clock_i(clock_i), .pull_i(pull), .async_i(use_a), .qoff_i(qoff),
    .wait_i(wt), .oe_i(oe), .s0_n_o(s0), .s1_n_o(s1), .async_ready_in_n_n_o(ar),
    .aq_n_o(aq), .sync_ready_in_n_n_o(sr), .sq_n_o(sq), .line_o(line));
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_strap(input logic s);
    @(posedge clock_i);
    rst_i <= 1'h1;
    strap <= s;
    xtal <= 1'h0;
    external_frequency_in <= 1'h1;
    tick(3);
    check("reset_o", 1'h1, rst_o);
    check("ready_oe_o", 1'h1, oe);
    check("system_clock_o", s, sclk);
    @(posedge clock_i);
    xtal <= 1'h1;
    external_frequency_in <= 1'h0;
    rst_i <= 1'h0;
    #1;
    check("system_clock_o", !s, sclk);
    for (n = 0; n < 12 && rst_o !== 1'h0; n++) tick(1);
    check("reset_o", 1'h0, rst_o);
  endtask
  task automatic t_pclk();
    logic prev;
    tick(1);
    prev = pclk;
    repeat (6) begin
      tick(1);
      check("pclk_o", !prev, pclk);
      prev = pclk;
    end
  endtask
  task automatic t_force();
    @(posedge clock_i);
    pull <= 2'h2;
    tick(1);
    repeat (3) begin
      tick(1);
      check("pclk_o forced", 1'h1, pclk);
    end
    @(posedge clock_i);
    pull <= 2'h0;
    tick(2);
  endtask
  // a, q: async source, qualifier withheld; w: wait states; e: ready expected
  task automatic t_ready(input logic a, input logic q, input logic [3:0] w, input logic e);
    @(posedge clock_i);
    use_a <= a;
    qoff <= q;
    wt <= w;
    pull <= 2'h1;
    @(posedge clock_i);
    pull <= 2'h0;
    #1;
    for (n = 0; n < 40 && oe !== 1'h1; n++) tick(1);
    check("ready_oe_o", e, oe);
    if (e) begin
      tick(1);
      check("ready_oe_o held", 1'h1, oe);
      check("ready_out_o", 1'h0, r_out);
      check("ready line", 1'h0, line);
      @(posedge clock_i);
      pull <= 2'h2;
      @(posedge clock_i);
      pull <= 2'h0;
      #1;
      check("ready_oe_o release", 1'h0, oe);
      // let the async synchronisers drain before the next bus cycle
      tick(6);
    end
  endtask
  task automatic t_req();
    @(posedge clock_i);
    req_n <= 1'h0;
    tick(1);
    check("reset_o early", 1'h0, rst_o);
    for (n = 0; n < 10 && rst_o !== 1'h1; n++) tick(1);
    check("reset_o", 1'h1, rst_o);
    tick(1);
    check("ready_oe_o", 1'h1, oe);
    @(posedge clock_i);
    req_n <= 1'h1;
    #1;
    for (n = 0; n < 10 && rst_o !== 1'h0; n++) tick(1);
    check("reset_o", 1'h0, rst_o);
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'h0;
    t_strap(1'h1);
    t_strap(1'h0);
    t_pclk();
    t_force();
    t_ready(1'h0, 1'h0, 4'h0, 1'h1);
    t_ready(1'h1, 1'h0, 4'h9, 1'h1);
    t_ready(1'h0, 1'h1, 4'h2, 1'h0);
    t_ready(1'h1, 1'h1, 4'h0, 1'h0);
    t_req();
    report_and_stop();
  end
  // the whole run needs well under 1000 cycles
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule
